// [design/hps_port_status_reply.sv]
// Port status request decode and four-byte reply for a hub
//
// Operation
// - Request is type A3h GET_STATUS, value zero, index port, length four.
// - Reply sends the status word first, then the change word.
// - Each change bit sits at the position of the status bit it tracks.
// - Stall on nonzero value, length not four, or a missing port.
// - Bit 0 is one while a device is present on the port.
// - Bit 1 shows enable; set when a port reset ends, cleared by software or faults.
// - Bit 2 shows suspend or resume; suspended ports get no traffic.
// - Bit 3 is one while the port draws over-current.
// - Bit 4 is one from reset request until reset signaling ends.
// - Bits 5 to 7 and 13 to 15 always read zero.
// - Bit 8 is zero only in the powered-off state.
// - Bit 9 is one for a low-speed device, meaningful when attached.
// - Bit 10 is one for high-speed, zero for full-speed, when attached.
// - Bit 11 shows test mode, changed only by feature requests.
// - Bit 12 is one while software controls the port indicator.
// - Enable is set only when a requested port reset finishes.
`timescale 1ns/10ps
module hps_port_status_reply (
	input wire logic clk,
	input wire logic reset,
	input wire logic setupValid,
	input wire logic [7:0] setupType,
	input wire logic [7:0] setupRequest,
	input wire logic [15:0] setupValue,
	input wire logic [15:0] setupIndex,
	input wire logic [15:0] setupLength,
	input wire logic inReq,
	input wire logic [hps_pkg::NPORT-1:0] portConnectPin,
	input wire logic [hps_pkg::NPORT-1:0] portOverCurrentPin,
	input wire logic [hps_pkg::NPORT-1:0] portLowSpeedPin,
	input wire logic [hps_pkg::NPORT-1:0] portHighSpeedPin,
	input wire logic [hps_pkg::NPORT*hps_pkg::CHG_W-1:0] changeBits,
	input wire logic [hps_pkg::NPORT-1:0] evSetPower,
	input wire logic [hps_pkg::NPORT-1:0] evClrPower,
	input wire logic [hps_pkg::NPORT-1:0] evSetReset,
	input wire logic [hps_pkg::NPORT-1:0] evResetDone,
	input wire logic [hps_pkg::NPORT-1:0] evClrEnable,
	input wire logic [hps_pkg::NPORT-1:0] evPortError,
	input wire logic [hps_pkg::NPORT-1:0] evSetSuspend,
	input wire logic [hps_pkg::NPORT-1:0] evResume,
	input wire logic [hps_pkg::NPORT-1:0] evSetTest,
	input wire logic [hps_pkg::NPORT-1:0] evClrTest,
	input wire logic [hps_pkg::NPORT-1:0] evSetIndicator,
	input wire logic [hps_pkg::NPORT-1:0] evClrIndicator,
	output logic reqAccept,
	output logic reqStall,
	output logic [7:0] replyByte,
	output logic replyValid,
	output logic replyLast,
	output logic [hps_pkg::NPORT-1:0] portForward
);

	typedef struct packed {
		hps_pkg::hps_state_t state;
		logic [1:0] byteIdx;
		logic [31:0] reply;
		logic accept;
		logic stall;
		logic [7:0] dataByte;
		logic dataValid;
		logic dataLast;
		logic [hps_pkg::NPORT-1:0] conn1;
		logic [hps_pkg::NPORT-1:0] conn2;
		logic [hps_pkg::NPORT-1:0] oc1;
		logic [hps_pkg::NPORT-1:0] oc2;
		logic [hps_pkg::NPORT-1:0] ls1;
		logic [hps_pkg::NPORT-1:0] ls2;
		logic [hps_pkg::NPORT-1:0] hs1;
		logic [hps_pkg::NPORT-1:0] hs2;
	} hps_main_t;

	localparam hps_main_t MAIN_RESET = '{
		state: hps_pkg::HPS_IDLE,
		byteIdx: hps_pkg::BYTE_FIRST,
		reply: hps_pkg::REPLY_RESET,
		accept: 1'b0,
		stall: 1'b0,
		dataByte: hps_pkg::BYTE_RESET,
		dataValid: 1'b0,
		dataLast: 1'b0,
		conn1: hps_pkg::PORTS_RESET,
		conn2: hps_pkg::PORTS_RESET,
		oc1: hps_pkg::PORTS_RESET,
		oc2: hps_pkg::PORTS_RESET,
		ls1: hps_pkg::PORTS_RESET,
		ls2: hps_pkg::PORTS_RESET,
		hs1: hps_pkg::PORTS_RESET,
		hs2: hps_pkg::PORTS_RESET
	};

	hps_main_t st_r;
	hps_main_t st_nxt;

	logic [hps_pkg::NPORT-1:0] pwr;
	logic [hps_pkg::NPORT-1:0] ena;
	logic [hps_pkg::NPORT-1:0] sus;
	logic [hps_pkg::NPORT-1:0] rst;
	logic [hps_pkg::NPORT-1:0] tst;
	logic [hps_pkg::NPORT-1:0] ind;
	logic [15:0] stsWord [hps_pkg::NPORT];
	logic [15:0] chgWord [hps_pkg::NPORT];
	logic [15:0] selSts;
	logic [15:0] selChg;
	logic isPortReq;
	logic badReq;

	////////////////////////////////////////////////////////////////////////
	// Per-port flag trackers, fed by synchronised pin levels

	hps_port_tracker hps_port_tracker_inst_0 (
		.clk(clk),
		.reset(reset),
		.connected(st_r.conn2[0]),
		.overCurrent(st_r.oc2[0]),
		.evSetPower(evSetPower[0]),
		.evClrPower(evClrPower[0]),
		.evSetReset(evSetReset[0]),
		.evResetDone(evResetDone[0]),
		.evClrEnable(evClrEnable[0]),
		.evPortError(evPortError[0]),
		.evSetSuspend(evSetSuspend[0]),
		.evResume(evResume[0]),
		.evSetTest(evSetTest[0]),
		.evClrTest(evClrTest[0]),
		.evSetIndicator(evSetIndicator[0]),
		.evClrIndicator(evClrIndicator[0]),
		.power(pwr[0]),
		.enable(ena[0]),
		.suspend(sus[0]),
		.resetting(rst[0]),
		.testMode(tst[0]),
		.indicator(ind[0]),
		.forward(portForward[0])
	);
	hps_port_tracker hps_port_tracker_inst_1 (
		.clk(clk),
		.reset(reset),
		.connected(st_r.conn2[1]),
		.overCurrent(st_r.oc2[1]),
		.evSetPower(evSetPower[1]),
		.evClrPower(evClrPower[1]),
		.evSetReset(evSetReset[1]),
		.evResetDone(evResetDone[1]),
		.evClrEnable(evClrEnable[1]),
		.evPortError(evPortError[1]),
		.evSetSuspend(evSetSuspend[1]),
		.evResume(evResume[1]),
		.evSetTest(evSetTest[1]),
		.evClrTest(evClrTest[1]),
		.evSetIndicator(evSetIndicator[1]),
		.evClrIndicator(evClrIndicator[1]),
		.power(pwr[1]),
		.enable(ena[1]),
		.suspend(sus[1]),
		.resetting(rst[1]),
		.testMode(tst[1]),
		.indicator(ind[1]),
		.forward(portForward[1])
	);
	hps_port_tracker hps_port_tracker_inst_2 (
		.clk(clk),
		.reset(reset),
		.connected(st_r.conn2[2]),
		.overCurrent(st_r.oc2[2]),
		.evSetPower(evSetPower[2]),
		.evClrPower(evClrPower[2]),
		.evSetReset(evSetReset[2]),
		.evResetDone(evResetDone[2]),
		.evClrEnable(evClrEnable[2]),
		.evPortError(evPortError[2]),
		.evSetSuspend(evSetSuspend[2]),
		.evResume(evResume[2]),
		.evSetTest(evSetTest[2]),
		.evClrTest(evClrTest[2]),
		.evSetIndicator(evSetIndicator[2]),
		.evClrIndicator(evClrIndicator[2]),
		.power(pwr[2]),
		.enable(ena[2]),
		.suspend(sus[2]),
		.resetting(rst[2]),
		.testMode(tst[2]),
		.indicator(ind[2]),
		.forward(portForward[2])
	);
	hps_port_tracker hps_port_tracker_inst_3 (
		.clk(clk),
		.reset(reset),
		.connected(st_r.conn2[3]),
		.overCurrent(st_r.oc2[3]),
		.evSetPower(evSetPower[3]),
		.evClrPower(evClrPower[3]),
		.evSetReset(evSetReset[3]),
		.evResetDone(evResetDone[3]),
		.evClrEnable(evClrEnable[3]),
		.evPortError(evPortError[3]),
		.evSetSuspend(evSetSuspend[3]),
		.evResume(evResume[3]),
		.evSetTest(evSetTest[3]),
		.evClrTest(evClrTest[3]),
		.evSetIndicator(evSetIndicator[3]),
		.evClrIndicator(evClrIndicator[3]),
		.power(pwr[3]),
		.enable(ena[3]),
		.suspend(sus[3]),
		.resetting(rst[3]),
		.testMode(tst[3]),
		.indicator(ind[3]),
		.forward(portForward[3])
	);

	////////////////////////////////////////////////////////////////////////
	// Status and change words per port

	always_comb begin
		for (int p = 0; p < hps_pkg::NPORT; p++) begin
			stsWord[p] = hps_pkg::WORD_RESET;
			stsWord[p][hps_pkg::BIT_CONN] = st_r.conn2[p];
			stsWord[p][hps_pkg::BIT_ENABLE] = ena[p];
			stsWord[p][hps_pkg::BIT_SUSPEND] = sus[p];
			stsWord[p][hps_pkg::BIT_OVERCUR] = st_r.oc2[p];
			stsWord[p][hps_pkg::BIT_RESET] = rst[p];
			stsWord[p][hps_pkg::BIT_POWER] = pwr[p];
			// Speed reads zero when nothing is attached
			stsWord[p][hps_pkg::BIT_LOWSPD] =
				st_r.ls2[p] && st_r.conn2[p];
			stsWord[p][hps_pkg::BIT_HIGHSPD] =
				st_r.hs2[p] && !st_r.ls2[p] && st_r.conn2[p];
			stsWord[p][hps_pkg::BIT_TEST] = tst[p];
			stsWord[p][hps_pkg::BIT_INDIC] = ind[p];
			// Change bits land on their status positions
			chgWord[p] = hps_pkg::WORD_RESET;
			chgWord[p][hps_pkg::CHG_W-1:0] =
				changeBits[p*hps_pkg::CHG_W +: hps_pkg::CHG_W];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Request decode; unknown port numbers select nothing

	always_comb begin
		selSts = hps_pkg::WORD_RESET;
		selChg = hps_pkg::WORD_RESET;
		for (int p = 0; p < hps_pkg::NPORT; p++) begin
			if (setupIndex == 16'(p + 1)) begin
				selSts = stsWord[p];
				selChg = chgWord[p];
			end
		end
		isPortReq = setupType == hps_pkg::REQ_TYPE_PORT
			&& setupRequest == hps_pkg::REQ_GET_STATUS;
		badReq = setupValue != hps_pkg::REQ_VALUE
			|| setupLength != hps_pkg::REQ_LENGTH
			|| setupIndex < hps_pkg::PORT_FIRST
			|| setupIndex > hps_pkg::PORT_LAST;
	end

	////////////////////////////////////////////////////////////////////////
	// Reply sequencer

	always_comb begin
		st_nxt = st_r;
		st_nxt.accept = 1'b0;
		st_nxt.stall = 1'b0;
		st_nxt.dataValid = 1'b0;
		st_nxt.dataLast = 1'b0;
		// Pin levels cross in through two flops
		st_nxt.conn1 = portConnectPin;
		st_nxt.conn2 = st_r.conn1;
		st_nxt.oc1 = portOverCurrentPin;
		st_nxt.oc2 = st_r.oc1;
		st_nxt.ls1 = portLowSpeedPin;
		st_nxt.ls2 = st_r.ls1;
		st_nxt.hs1 = portHighSpeedPin;
		st_nxt.hs2 = st_r.hs1;
		// A new setup always supersedes an unfinished reply
		if (setupValid && isPortReq) begin
			st_nxt.byteIdx = hps_pkg::BYTE_FIRST;
			if (badReq) begin
				st_nxt.stall = 1'b1;
				st_nxt.state = hps_pkg::HPS_IDLE;
			end else begin
				st_nxt.accept = 1'b1;
				// Snapshot keeps both words coherent
				st_nxt.reply = {selChg, selSts};
				st_nxt.state = hps_pkg::HPS_SEND;
			end
		end else if (setupValid) begin
			st_nxt.state = hps_pkg::HPS_IDLE;
		end else begin
			case (st_r.state)
				hps_pkg::HPS_IDLE: begin
					st_nxt.byteIdx = hps_pkg::BYTE_FIRST;
				end
				hps_pkg::HPS_SEND: begin
					if (inReq) begin
						// Low byte of each word first
						st_nxt.dataByte =
							st_r.reply[8*st_r.byteIdx +: 8];
						st_nxt.dataValid = 1'b1;
						st_nxt.byteIdx = st_r.byteIdx + 2'h1;
						if (st_r.byteIdx == hps_pkg::BYTE_LAST) begin
							st_nxt.dataLast = 1'b1;
							st_nxt.state = hps_pkg::HPS_IDLE;
						end
					end
				end
				default: begin
					st_nxt.state = hps_pkg::HPS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			st_r <= MAIN_RESET;
		else
			st_r <= st_nxt;
	end

	assign reqAccept = st_r.accept;
	assign reqStall = st_r.stall;
	assign replyByte = st_r.dataByte;
	assign replyValid = st_r.dataValid;
	assign replyLast = st_r.dataLast;

endmodule : hps_port_status_reply

// [design/hps_pkg.sv]
// Constants shared by the hub port status reply logic
package hps_pkg;

	// Hub shape
	localparam int NPORT = 4;
	localparam int CHG_W = 5;

	// Request decode
	localparam logic [7:0] REQ_TYPE_PORT = 8'hA3;
	localparam logic [7:0] REQ_GET_STATUS = 8'h00;
	localparam logic [15:0] REQ_VALUE = 16'h0000;
	localparam logic [15:0] REQ_LENGTH = 16'h0004;
	localparam logic [15:0] PORT_FIRST = 16'h0001;
	localparam logic [15:0] PORT_LAST = 16'h0004;

	// Reply framing
	localparam logic [1:0] BYTE_FIRST = 2'h0;
	localparam logic [1:0] BYTE_LAST = 2'h3;

	// Status word bit positions
	localparam int BIT_CONN = 0;
	localparam int BIT_ENABLE = 1;
	localparam int BIT_SUSPEND = 2;
	localparam int BIT_OVERCUR = 3;
	localparam int BIT_RESET = 4;
	localparam int BIT_POWER = 8;
	localparam int BIT_LOWSPD = 9;
	localparam int BIT_HIGHSPD = 10;
	localparam int BIT_TEST = 11;
	localparam int BIT_INDIC = 12;

	// Values after reset
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [31:0] REPLY_RESET = 32'h0000_0000;
	localparam logic [NPORT-1:0] PORTS_RESET = 4'h0;

	typedef enum {
		HPS_IDLE,
		HPS_SEND
	} hps_state_t;

endpackage : hps_pkg

// [design/hps_port_tracker.sv]
// Per-port status flags driven by the hub's port request events
`timescale 1ns/10ps
module hps_port_tracker (
	input wire logic clk,
	input wire logic reset,
	input wire logic connected,
	input wire logic overCurrent,
	input wire logic evSetPower,
	input wire logic evClrPower,
	input wire logic evSetReset,
	input wire logic evResetDone,
	input wire logic evClrEnable,
	input wire logic evPortError,
	input wire logic evSetSuspend,
	input wire logic evResume,
	input wire logic evSetTest,
	input wire logic evClrTest,
	input wire logic evSetIndicator,
	input wire logic evClrIndicator,
	output logic power,
	output logic enable,
	output logic suspend,
	output logic resetting,
	output logic testMode,
	output logic indicator,
	output logic forward
);

	typedef struct packed {
		logic power;
		logic enable;
		logic suspend;
		logic resetting;
		logic testMode;
		logic indicator;
		logic forward;
	} hps_trk_t;

	hps_trk_t st_r;
	hps_trk_t st_nxt;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		if (evSetPower)
			st_nxt.power = 1'b1;
		if (evClrPower || overCurrent)
			st_nxt.power = 1'b0;
		// Reset only from a powered, attached, non-test port
		if (evSetReset && st_r.power && connected && !st_r.testMode) begin
			st_nxt.resetting = 1'b1;
			st_nxt.enable = 1'b0;
		end
		// Enable rises only when reset signaling ends
		if (evResetDone && st_r.resetting) begin
			st_nxt.resetting = 1'b0;
			st_nxt.enable = 1'b1;
		end
		if (evClrEnable || evPortError || !connected)
			st_nxt.enable = 1'b0;
		if (evSetSuspend && st_r.enable)
			st_nxt.suspend = 1'b1;
		if (evResume || !st_nxt.enable)
			st_nxt.suspend = 1'b0;
		// Test entry refused on an enabled, running port
		if (evSetTest && (!st_r.enable || st_r.suspend))
			st_nxt.testMode = 1'b1;
		if (evClrTest)
			st_nxt.testMode = 1'b0;
		if (evSetIndicator)
			st_nxt.indicator = 1'b1;
		if (evClrIndicator)
			st_nxt.indicator = 1'b0;
		if (!st_nxt.power) begin
			st_nxt.enable = 1'b0;
			st_nxt.suspend = 1'b0;
			st_nxt.resetting = 1'b0;
		end
		// Suspended ports get no downstream traffic
		st_nxt.forward = st_nxt.enable && !st_nxt.suspend
			&& !st_nxt.resetting;
	end

	always_ff @(posedge clk) begin
		if (reset)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign power = st_r.power;
	assign enable = st_r.enable;
	assign suspend = st_r.suspend;
	assign resetting = st_r.resetting;
	assign testMode = st_r.testMode;
	assign indicator = st_r.indicator;
	assign forward = st_r.forward;

endmodule : hps_port_tracker

// [dv/hps_port_status_reply_chk.sv]
// Port-level assertions for the port status reply block
`timescale 1ns/10ps
module hps_port_status_reply_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic setupValid,
	input wire logic [7:0] setupType,
	input wire logic [7:0] setupRequest,
	input wire logic [15:0] setupValue,
	input wire logic [15:0] setupIndex,
	input wire logic [15:0] setupLength,
	input wire logic inReq,
	input wire logic [3:0] evResetDone,
	input wire logic [3:0] evResume,
	input wire logic reqAccept,
	input wire logic reqStall,
	input wire logic [7:0] replyByte,
	input wire logic replyValid,
	input wire logic replyLast,
	input wire logic [3:0] portForward
);
	logic [1:0] byteCnt_r;
	logic portReq;
	logic badReq;
	assign portReq = setupValid && setupType == hps_pkg::REQ_TYPE_PORT
		&& setupRequest == hps_pkg::REQ_GET_STATUS;
	assign badReq = setupValue != 16'h0000 || setupLength != 16'h0004
		|| setupIndex < 16'h0001 || setupIndex > 16'h0004;
	// Reply position; any setup restarts it, as an abort must
	always_ff @(posedge clk) begin
		if (reset || setupValid)
			byteCnt_r <= 2'h0;
		else if (replyValid)
			byteCnt_r <= byteCnt_r + 2'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence sAccepted;
		reqAccept && !inReq;
	endsequence
	sequence sFourPulls;
		(inReq && !setupValid)[*4];
	endsequence
	chk_bad_stall: assert property (
		portReq && badReq |=> reqStall && !reqAccept)
		else $error("bad port request not stalled");
	chk_good_accept: assert property (
		portReq && !badReq |=> reqAccept && !reqStall)
		else $error("good port request not accepted");
	chk_quiet_other: assert property (
		!portReq |=> !reqAccept && !reqStall)
		else $error("answer without a port request");
	chk_reply_last: assert property (
		sAccepted ##1 sFourPulls |=> replyValid && replyLast)
		else $error("fourth byte not marked last");
	chk_byte_pos: assert property (
		replyValid |-> replyLast == (byteCnt_r == 2'h3) && $past(inReq))
		else $error("reply byte out of place");
	chk_reserved_zero: assert property (
		replyValid && byteCnt_r != 2'h3 |-> replyByte[7:5] == 3'h0)
		else $error("reserved reply bits set");
	chk_change_high: assert property (
		replyValid && byteCnt_r == 2'h3 |-> replyByte == 8'h00)
		else $error("change word high byte not zero");
	chk_enable_cause: assert property (
		(portForward & ~$past(portForward) & ~($past(evResetDone)
		| $past(evResume) | $past(evResetDone, 2) | $past(evResume, 2)))
		== 4'h0)
		else $error("port forwarding began without cause");
endmodule : hps_port_status_reply_chk
bind hps_port_status_reply hps_port_status_reply_chk chk_inst (
	.clk(clk), .reset(reset), .setupValid(setupValid),
	.setupType(setupType), .setupRequest(setupRequest),
	.setupValue(setupValue), .setupIndex(setupIndex),
	.setupLength(setupLength), .inReq(inReq), .evResetDone(evResetDone),
	.evResume(evResume), .reqAccept(reqAccept), .reqStall(reqStall),
	.replyByte(replyByte), .replyValid(replyValid),
	.replyLast(replyLast), .portForward(portForward));

// [dv/hps_host_model.sv]
// Host side model issuing setup packets and pulling reply bytes
`timescale 1ns/10ps
module hps_host_model (
	input wire logic clk,
	output logic setupValid,
	output logic [7:0] setupType,
	output logic [7:0] setupRequest,
	output logic [15:0] setupValue,
	output logic [15:0] setupIndex,
	output logic [15:0] setupLength,
	output logic inReq
);
	initial begin
		{setupValid, inReq} = 2'h0;
		{setupType, setupRequest, setupValue, setupIndex} = 48'h0;
		setupLength = 16'h0;
	end
	task automatic setup(input logic [7:0] t, input logic [15:0] v,
		input logic [15:0] i, input logic [15:0] l);
		@(posedge clk);
		setupValid <= 1'h1;
		{setupType, setupRequest} <= {t, hps_pkg::REQ_GET_STATUS};
		{setupValue, setupIndex, setupLength} <= {v, i, l};
		@(posedge clk);
		setupValid <= 1'h0;
		// Junk outside the valid cycle exposes late sampling
		{setupValue, setupIndex, setupLength} <= ~{v, i, l};
	endtask : setup
	task automatic burst(input int n);
		@(posedge clk);
		inReq <= 1'h1;
		repeat (n) @(posedge clk);
		inReq <= 1'h0;
	endtask : burst
endmodule : hps_host_model

// [dv/hps_port_status_reply_tb.sv]
// Self-checking bench for the port status reply block
`timescale 1ns/10ps
module hps_port_status_reply_tb;
	logic clk;
	logic reset;
	logic setupValid, inReq, reqAccept, reqStall, replyValid, replyLast;
	logic [7:0] setupType, setupRequest, replyByte;
	logic [15:0] setupValue, setupIndex, setupLength;
	logic [3:0] conn, overCur, lowSpd, highSpd, portForward;
	logic [19:0] changeBits;
	logic [11:0][3:0] ev;
	logic [8:0] got[$];
	int failures;
	int testsRun;
	// Events: power on/off, reset on/done, enable off, error, suspend,
	// resume, test on/off, indicator on/off; 16 up sets pins
	int ks[22] = '{24, 0, 2, 3, 26, 25, 6, 8, 9, 7, 8, 10, 11, 4, 2, 3, 5,
		29, 25, 0, 1, 16};
	logic [15:0] ex[22] = '{16'h0001, 16'h0101, 16'h0111, 16'h0103,
		16'h0303, 16'h0503, 16'h0507, 16'h0D07, 16'h0507, 16'h0503,
		16'h0503, 16'h1503, 16'h0503, 16'h0501, 16'h0511, 16'h0503,
		16'h0501, 16'h0409, 16'h0401, 16'h0501, 16'h0401, 16'h0000};
	hps_host_model host (.clk(clk), .setupValid(setupValid),
		.setupType(setupType), .setupRequest(setupRequest),
		.setupValue(setupValue), .setupIndex(setupIndex),
		.setupLength(setupLength), .inReq(inReq));
	hps_port_status_reply hps_port_status_reply_inst (.clk(clk),
		.reset(reset), .setupValid(setupValid), .setupType(setupType),
		.setupRequest(setupRequest), .setupValue(setupValue),
		.setupIndex(setupIndex), .setupLength(setupLength), .inReq(inReq),
		.portConnectPin(conn), .portOverCurrentPin(overCur),
		.portLowSpeedPin(lowSpd), .portHighSpeedPin(highSpd),
		.changeBits(changeBits), .evSetPower(ev[0]), .evClrPower(ev[1]),
		.evSetReset(ev[2]), .evResetDone(ev[3]), .evClrEnable(ev[4]),
		.evPortError(ev[5]), .evSetSuspend(ev[6]), .evResume(ev[7]),
		.evSetTest(ev[8]), .evClrTest(ev[9]), .evSetIndicator(ev[10]),
		.evClrIndicator(ev[11]), .reqAccept(reqAccept),
		.reqStall(reqStall), .replyByte(replyByte),
		.replyValid(replyValid), .replyLast(replyLast),
		.portForward(portForward));
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk)
		if (replyValid === 1'h1)
			got.push_back({replyLast, replyByte});
	task automatic check(input logic [15:0] seen, input logic [15:0] exp,
		input string what);
		testsRun++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: %s %h not %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", testsRun, failures);
		if (failures == 0 && testsRun > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	task automatic getStatus(input logic [15:0] idx, input logic [15:0] val,
		input logic [15:0] len, input logic ok, input logic [15:0] st,
		input logic [15:0] chg);
		logic [35:0] e;
		e = {1'h1, chg[15:8], 1'h0, chg[7:0], 1'h0, st[15:8], 1'h0, st[7:0]};
		host.setup(hps_pkg::REQ_TYPE_PORT, val, idx, len);
		#1;
		got.delete();
		check({15'h0, reqAccept}, {15'h0, ok}, "accept");
		check({15'h0, reqStall}, {15'h0, ~ok}, "stall");
		host.burst(ok ? 4 : 1);
		repeat (2) @(posedge clk);
		#1;
		check(16'(got.size()), ok ? 16'h4 : 16'h0, "count");
		for (int k = 0; k < 4; k++)
			if (ok && got.size() == 4)
				check({7'h0, got[k]}, {7'h0, e[9 * k +: 9]}, "byte");
	endtask : getStatus
	task automatic fire(input int k, input int p);
		@(posedge clk);
		ev[k][p] <= 1'h1;
		@(posedge clk);
		ev <= 48'h0;
	endtask : fire
	task automatic pins(input int p, input logic [3:0] v);
		@(posedge clk);
		{conn[p], overCur[p], lowSpd[p], highSpd[p]} <= v;
		repeat (3) @(posedge clk);
	endtask : pins
	initial begin
		reset = 1'h1;
		{conn, overCur, lowSpd, highSpd, changeBits, ev} = 84'h0;
		failures = 0;
		testsRun = 0;
		repeat (2) @(posedge clk);
		reset <= 1'h0;
		getStatus(16'h1, 16'h0, 16'h4, 1'h1, 16'h0, 16'h0);
		host.setup(hps_pkg::REQ_TYPE_PORT, 16'h0, 16'h2, 16'h4);
		host.burst(2);
		getStatus(16'h3, 16'h0, 16'h4, 1'h1, 16'h0, 16'h0);
		getStatus(16'h0, 16'h0, 16'h4, 1'h0, 16'h0, 16'h0);
		getStatus(16'h5, 16'h0, 16'h4, 1'h0, 16'h0, 16'h0);
		getStatus(16'h0101, 16'h0, 16'h4, 1'h0, 16'h0, 16'h0);
		getStatus(16'h1, 16'h1, 16'h4, 1'h0, 16'h0, 16'h0);
		getStatus(16'h1, 16'h0, 16'h2, 1'h0, 16'h0, 16'h0);
		host.setup(8'h80, 16'h0, 16'h1, 16'h4);
		#1;
		check({14'h0, reqAccept, reqStall}, 16'h0, "ignored");
		$display("Request decode test done");
		for (int p = 0; p < 4; p++) begin
			@(posedge clk);
			changeBits <= 20'h00015 << (5 * p);
			for (int s = 0; s < 22; s++) begin
				if (ks[s] >= 16)
					pins(p, 4'(ks[s] - 16));
				else
					fire(ks[s], p);
				getStatus(16'(p + 1), 16'h0, 16'h4, 1'h1, ex[s], 16'h15);
				check({15'h0, portForward[p]},
					{15'h0, ex[s][1] & ~ex[s][2] & ~ex[s][4]}, "fwd");
			end
			$display("Port %0d status test done", p + 1);
		end
		test_done;
	end
	initial begin
		repeat (50000) @(posedge clk);
		failures++;
		test_done;
	end
endmodule : hps_port_status_reply_tb
